// *** inc/atarl_defs.svh ***
// register offsets, field positions, opcodes and counts of the read engine
`ifndef ATARL_DEFS_SVH
`define ATARL_DEFS_SVH
// task-file offsets on the three address pins
`define ATARL_A_DATA 3'h0
`define ATARL_A_ERR 3'h1
`define ATARL_A_SCNT 3'h2
`define ATARL_A_SNUM 3'h3
`define ATARL_A_CYLL 3'h4
`define ATARL_A_CYLH 3'h5
`define ATARL_A_DEVH 3'h6
`define ATARL_A_STAT 3'h7
// opcodes
`define ATARL_OP_LONG 8'h22
`define ATARL_OP_MULT 8'hC4
// error bit positions
`define ATARL_E_UNC 6
`define ATARL_E_IDNF 4
`define ATARL_E_ABRT 2
`define ATARL_E_AMNF 0
// status bit positions
`define ATARL_S_BSY 7
`define ATARL_S_DRDY 6
`define ATARL_S_DSC 4
`define ATARL_S_DRQ 3
`define ATARL_S_ERR 0
// address mode bit of the head select register
`define ATARL_DH_LBA 6
// reset values
`define ATARL_RST_TF 8'h00
`define ATARL_RST_DEVH 8'hA0
`define ATARL_RST_SCNT 8'h01
// counts
`define ATARL_SECT_WORDS 9'h100
`define ATARL_ECC_SHORT 9'h004
`define ATARL_ECC_LONG 9'h028
`define ATARL_ECC_INT 9'h034
`define ATARL_FIFO_W 16
`define ATARL_FIFO_D 16
`endif

// *** inc/atarl_pkg.sv ***
// types of the read engine
package atarl_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_XFER = 2'b11,
		ST_DONE = 2'b10
	} atarl_state_e;
	typedef enum logic [1:0] {
		CM_NONE = 2'b00,
		CM_LONG = 2'b01,
		CM_MULT = 2'b10
	} atarl_cmd_e;
endpackage

// *** inc/atarl_strm_if.sv ***
// valid/ready word stream between the engine and its buffer
`timescale 1ns/1ps
interface atarl_strm_if #(parameter int W = 16);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// *** verilog/atarl_fifo.sv ***
// flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module atarl_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	atarl_strm_if.snk wr,
	atarl_strm_if.src rd
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;

	// honest full and empty from the fill count
	assign wr.ready = (cnt != (AW+1)'(D));
	assign rd.valid = (cnt != '0);
	assign rd.data = mem[rp];
	assign push = wr.valid & wr.ready;
	assign pop = rd.valid & rd.ready;

	// storage written at the write pointer
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp] <= wr.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else if (flush_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			unique case ({push, pop})
				2'b10: cnt <= cnt + 1'b1;
				2'b01: cnt <= cnt - 1'b1;
				default: cnt <= cnt;
			endcase
		end
	end
endmodule

// *** verilog/atarl_core.sv ***
// task-file command engine for the raw sector read and multi-sector read
`timescale 1ns/1ps
`include "atarl_defs.svh"
module atarl_core (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [2:0] tf_addr_i,
	input wire logic tf_rd_n_i,
	input wire logic tf_wr_n_i,
	input wire logic [15:0] tf_data_i,
	output logic [15:0] tf_data_o,
	output logic tf_data_oe_o,
	output logic intrq_o,
	input wire logic ecc40_sel_i,
	input wire logic [7:0] block_size_i,
	output logic media_start_o,
	output logic [27:0] media_addr_o,
	output logic media_lba_o,
	output logic [8:0] media_count_o,
	input wire logic media_valid_i,
	input wire logic [15:0] media_data_i,
	output logic media_ready_o,
	input wire logic media_unc_i,
	input wire logic media_idnf_i,
	input wire logic media_amnf_i
);
	logic [1:0] rst_sync;
	logic rst_n;
	logic [2:0] rd_s;
	logic [2:0] wr_s;
	logic rd_act;
	logic wr_act;
	logic rd_go;
	logic wr_go;
	atarl_pkg::atarl_state_e state;
	atarl_pkg::atarl_cmd_e cmd;
	logic [7:0] sec_count;
	logic [7:0] sec_num;
	logic [7:0] cyl_lo;
	logic [7:0] cyl_hi;
	logic [7:0] drive_head_select;
	logic [7:0] command_error_flags;
	logic [7:0] device_condition_flags;
	logic err_st;
	logic [8:0] ecc_len;
	logic [8:0] out_len;
	logic [8:0] out_cnt;
	logic [8:0] secs_left;
	logic [7:0] blk_size;
	logic [7:0] blk_left;
	logic [8:0] in_cnt;
	logic [8:0] in_secs;
	logic in_fwd;
	logic in_last;
	logic stream_done;
	logic pop;
	logic out_last;
	logic cmd_go;
	logic err_hit;
	logic [7:0] err_bits;
	logic [27:0] cur_addr;
	logic [27:0] next_addr;
	logic [8:0] req_secs;
	logic active;
	logic flush;
	atarl_strm_if #(.W(`ATARL_FIFO_W)) buf_in ();
	atarl_strm_if #(.W(`ATARL_FIFO_W)) buf_out ();

	// reset release through two flops
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// strobe pins pass three flops; a level counts once stages 2 and 3 agree
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_s <= 3'h7;
			wr_s <= 3'h7;
			rd_act <= 1'b0;
			wr_act <= 1'b0;
		end else begin
			rd_s <= {rd_s[1:0], tf_rd_n_i};
			wr_s <= {wr_s[1:0], tf_wr_n_i};
			if (rd_s[1] == rd_s[2]) begin
				rd_act <= ~rd_s[2];
			end
			if (wr_s[1] == wr_s[2]) begin
				wr_act <= ~wr_s[2];
			end
		end
	end
	assign rd_go = (rd_s[1] == rd_s[2]) & ~rd_s[2] & ~rd_act;
	assign wr_go = (wr_s[1] == wr_s[2]) & ~wr_s[2] & ~wr_act;
	assign tf_data_oe_o = rd_act;

	// address as split by the mode bit; head nibble gives the top bits
	assign cur_addr = {drive_head_select[3:0], cyl_hi, cyl_lo, sec_num};
	assign next_addr = drive_head_select[`ATARL_DH_LBA] ?
		cur_addr + 28'h0000001 :
		{cur_addr[27:8], sec_num + 8'h01};
	assign req_secs = (sec_count == 8'h00) ? `ATARL_SECT_WORDS :
		{1'b0, sec_count};
	assign cmd_go = wr_go && tf_addr_i == `ATARL_A_STAT &&
		state == atarl_pkg::ST_IDLE;

	// status byte assembled from the engine state
	always_comb begin
		device_condition_flags = 8'h00;
		device_condition_flags[`ATARL_S_BSY] = (state == atarl_pkg::ST_FILL) ||
			(state == atarl_pkg::ST_DONE);
		device_condition_flags[`ATARL_S_DRDY] = 1'b1;
		device_condition_flags[`ATARL_S_DSC] = 1'b1;
		device_condition_flags[`ATARL_S_DRQ] = (state == atarl_pkg::ST_XFER);
		device_condition_flags[`ATARL_S_ERR] = err_st;
	end

	// media faults; the raw read never looks at ECC results
	always_comb begin
		err_bits = 8'h00;
		err_bits[`ATARL_E_UNC] = media_unc_i && cmd == atarl_pkg::CM_MULT;
		err_bits[`ATARL_E_IDNF] = media_idnf_i;
		err_bits[`ATARL_E_AMNF] = media_amnf_i;
	end
	assign active = (state == atarl_pkg::ST_FILL) ||
		(state == atarl_pkg::ST_XFER);
	assign err_hit = active && (err_bits != 8'h00);
	assign flush = err_hit || state == atarl_pkg::ST_DONE;

	// host-side length of one sector: data words then ECC bytes
	assign out_len = (cmd == atarl_pkg::CM_LONG) ?
		`ATARL_SECT_WORDS + ecc_len : `ATARL_SECT_WORDS;
	assign pop = rd_go && tf_addr_i == `ATARL_A_DATA &&
		state == atarl_pkg::ST_XFER && buf_out.valid;
	assign buf_out.ready = pop;
	assign out_last = (out_cnt == out_len - 9'h001);

	// media side: 256 words and 52 ECC bytes per sector, ECC forwarded
	// only for the raw read and only as far as the chosen length
	assign in_last = (in_cnt == `ATARL_SECT_WORDS + `ATARL_ECC_INT - 9'h001);
	assign in_fwd = (in_cnt < `ATARL_SECT_WORDS) ||
		(cmd == atarl_pkg::CM_LONG &&
		in_cnt < `ATARL_SECT_WORDS + ecc_len);
	assign stream_done = (in_secs == 9'h000);
	assign buf_in.valid = media_valid_i && active && !stream_done && in_fwd;
	assign buf_in.data = media_data_i;
	assign media_ready_o = active && !stream_done &&
		(in_fwd ? buf_in.ready : 1'b1);

	// incoming word and sector counts
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			in_cnt <= 9'h000;
			in_secs <= 9'h000;
		end else if (cmd_go) begin
			in_cnt <= 9'h000;
			in_secs <= (tf_data_i[7:1] == `ATARL_OP_LONG >> 1) ? 9'h001 :
				req_secs;
		end else if (media_valid_i && media_ready_o) begin
			if (in_last) begin
				in_cnt <= 9'h000;
				in_secs <= in_secs - 9'h001;
			end else begin
				in_cnt <= in_cnt + 9'h001;
			end
		end
	end

	// media request, one per accepted command with the start address
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			media_start_o <= 1'b0;
			media_addr_o <= 28'h0000000;
			media_lba_o <= 1'b0;
			media_count_o <= 9'h000;
		end else begin
			media_start_o <= cmd_go && state == atarl_pkg::ST_IDLE &&
				(tf_data_i[7:1] == `ATARL_OP_LONG >> 1 ? sec_count == 8'h01 :
				tf_data_i[7:0] == `ATARL_OP_MULT && block_size_i != 8'h00);
			if (cmd_go) begin
				media_addr_o <= cur_addr;
				media_lba_o <= drive_head_select[`ATARL_DH_LBA];
				media_count_o <= (tf_data_i[7:1] == `ATARL_OP_LONG >> 1) ?
					9'h001 : req_secs;
			end
		end
	end

	// command decode and transfer sequence
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= atarl_pkg::ST_IDLE;
			cmd <= atarl_pkg::CM_NONE;
			ecc_len <= `ATARL_ECC_SHORT;
			blk_size <= 8'h01;
		end else begin
			unique case (state)
				atarl_pkg::ST_IDLE: begin
					if (cmd_go) begin
						state <= atarl_pkg::ST_DONE;
						cmd <= atarl_pkg::CM_NONE;
						if (tf_data_i[7:1] == `ATARL_OP_LONG >> 1) begin
							if (sec_count == 8'h01) begin
								state <= atarl_pkg::ST_FILL;
								cmd <= atarl_pkg::CM_LONG;
							end
							blk_size <= 8'h01;
							ecc_len <= ecc40_sel_i ? `ATARL_ECC_LONG :
								`ATARL_ECC_SHORT;
						end else if (tf_data_i[7:0] == `ATARL_OP_MULT &&
							block_size_i != 8'h00) begin
							state <= atarl_pkg::ST_FILL;
							cmd <= atarl_pkg::CM_MULT;
							blk_size <= block_size_i;
						end
					end
				end
				atarl_pkg::ST_FILL: begin
					// wait for a full buffer or the whole stream
					if (err_hit) begin
						state <= atarl_pkg::ST_DONE;
					end else if (buf_out.valid && (!buf_in.ready || stream_done)) begin
						state <= atarl_pkg::ST_XFER;
					end
				end
				atarl_pkg::ST_XFER: begin
					if (err_hit || (pop && out_last && secs_left == 9'h001)) begin
						state <= atarl_pkg::ST_DONE;
					end else if (pop && out_last && blk_left == 8'h01) begin
						state <= atarl_pkg::ST_FILL;
					end
				end
				atarl_pkg::ST_DONE: begin
					state <= atarl_pkg::ST_IDLE;
					cmd <= atarl_pkg::CM_NONE;
				end
			endcase
		end
	end

	// host-side word, sector and block counts
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			out_cnt <= 9'h000;
			secs_left <= 9'h000;
			blk_left <= 8'h00;
		end else if (cmd_go) begin
			out_cnt <= 9'h000;
			secs_left <= (tf_data_i[7:1] == `ATARL_OP_LONG >> 1) ? 9'h001 :
				req_secs;
			blk_left <= (tf_data_i[7:0] == `ATARL_OP_MULT) ? block_size_i :
				8'h01;
		end else if (pop) begin
			if (out_last) begin
				out_cnt <= 9'h000;
				secs_left <= secs_left - 9'h001;
				blk_left <= (blk_left == 8'h01) ? blk_size : blk_left - 8'h01;
			end else begin
				out_cnt <= out_cnt + 9'h001;
			end
		end
	end

	// interrupt: raised per block and on a failed command, cleared by a
	// status read or a new command; raising wins over clearing
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			intrq_o <= 1'b0;
		end else if ((state == atarl_pkg::ST_FILL && !err_hit &&
			buf_out.valid && (!buf_in.ready || stream_done)) ||
			(state == atarl_pkg::ST_DONE && err_st)) begin
			intrq_o <= 1'b1;
		end else if ((rd_go && tf_addr_i == `ATARL_A_STAT) || cmd_go) begin
			intrq_o <= 1'b0;
		end
	end

	// task-file registers: host writes while idle, address advanced per sector, count at completion
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			sec_count <= `ATARL_RST_SCNT;
			sec_num <= `ATARL_RST_SCNT;
			cyl_lo <= `ATARL_RST_TF;
			cyl_hi <= `ATARL_RST_TF;
			drive_head_select <= `ATARL_RST_DEVH;
			command_error_flags <= `ATARL_RST_TF;
			err_st <= 1'b0;
		end else begin
			if (wr_go && state == atarl_pkg::ST_IDLE) begin
				unique case (tf_addr_i)
					`ATARL_A_SCNT: sec_count <= tf_data_i[7:0];
					`ATARL_A_SNUM: sec_num <= tf_data_i[7:0];
					`ATARL_A_CYLL: cyl_lo <= tf_data_i[7:0];
					`ATARL_A_CYLH: cyl_hi <= tf_data_i[7:0];
					`ATARL_A_DEVH: drive_head_select <= tf_data_i[7:0];
					default: ;
				endcase
			end
			if (cmd_go) begin
				command_error_flags <= `ATARL_RST_TF;
				err_st <= 1'b0;
				if (!(tf_data_i[7:1] == `ATARL_OP_LONG >> 1 &&
					sec_count == 8'h01) && !(tf_data_i[7:0] ==
					`ATARL_OP_MULT && block_size_i != 8'h00)) begin
					command_error_flags[`ATARL_E_ABRT] <= 1'b1;
					err_st <= 1'b1;
				end
			end
			if (err_hit) begin
				command_error_flags <= err_bits;
				err_st <= 1'b1;
			end
			// advance to the next sector once the previous one is handed over
			if (pop && out_last && secs_left != 9'h001) begin
				{drive_head_select[3:0], cyl_hi, cyl_lo, sec_num} <= next_addr;
			end
			if (state == atarl_pkg::ST_DONE && cmd != atarl_pkg::CM_NONE) begin
				sec_count <= secs_left[7:0];
			end
		end
	end

	// read data latched at the counted strobe; ECC bytes in the low lane
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			tf_data_o <= 16'h0000;
		end else if (rd_go) begin
			unique case (tf_addr_i)
				`ATARL_A_DATA: tf_data_o <= !pop ? 16'h0000 :
					(out_cnt < `ATARL_SECT_WORDS) ? buf_out.data :
					{8'h00, buf_out.data[7:0]};
				`ATARL_A_ERR: tf_data_o <= {8'h00, command_error_flags};
				`ATARL_A_SCNT: tf_data_o <= {8'h00, sec_count};
				`ATARL_A_SNUM: tf_data_o <= {8'h00, sec_num};
				`ATARL_A_CYLL: tf_data_o <= {8'h00, cyl_lo};
				`ATARL_A_CYLH: tf_data_o <= {8'h00, cyl_hi};
				`ATARL_A_DEVH: tf_data_o <= {8'h00, drive_head_select};
				`ATARL_A_STAT: tf_data_o <= {8'h00, device_condition_flags};
			endcase
		end
	end

	// sector buffer between media and host
	atarl_fifo #(.W(`ATARL_FIFO_W), .D(`ATARL_FIFO_D)) u_buf (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.flush_i(flush),
		.wr(buf_in.snk),
		.rd(buf_out.src)
	);
endmodule

// *** tb/atarl_core_asserts.sv ***
// port assertions and covers for the read engine
`timescale 1ns/1ps
module atarl_core_chk (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic tf_rd_n_i,
	input wire logic tf_wr_n_i,
	input wire logic tf_data_oe_o,
	input wire logic intrq_o,
	input wire logic media_start_o,
	input wire logic [8:0] media_count_o,
	input wire logic media_ready_o
);
	logic [3:0] rd_age;
	logic [3:0] wr_age;
	logic started;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// cycles since the read strobe was last low, saturating
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) rd_age <= 4'hF;
		else if (!tf_rd_n_i) rd_age <= 4'h0;
		else if (rd_age != 4'hF) rd_age <= rd_age + 4'h1;
	end
	// cycles since the write strobe was last low, saturating
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) wr_age <= 4'hF;
		else if (!tf_wr_n_i) wr_age <= 4'h0;
		else if (wr_age != 4'hF) wr_age <= wr_age + 4'h1;
	end
	// a media fetch has been asked for since reset
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) started <= 1'b0;
		else started <= started | media_start_o;
	end
	a_start_pulse: assert property (media_start_o |=> !media_start_o[*8])
		else $error("media start is not a lone pulse");
	a_start_cmd: assert property (media_start_o |-> wr_age < 4'h8)
		else $error("media start without a command write");
	a_start_count: assert property (media_start_o |->
		media_count_o != 9'h000 && media_count_o <= 9'h100)
		else $error("media sector count out of range");
	a_start_ready: assert property (media_start_o |-> ##[1:40] media_ready_o)
		else $error("media not accepted after start");
	a_ready_idle: assert property (!started && !media_start_o |->
		!media_ready_o) else $error("media ready before any fetch");
	a_oe_idle: assert property (tf_rd_n_i[*6] |-> !tf_data_oe_o)
		else $error("data bus driven without read strobe");
	a_oe_sync: assert property ($rose(tf_data_oe_o) |->
		$past(!tf_rd_n_i, 2) && $past(!tf_rd_n_i, 3))
		else $error("data bus driven too early");
	a_intrq_clear: assert property ($fell(intrq_o) |-> rd_age < 4'h8)
		else $error("interrupt dropped without a host read");
	cover property ($rose(intrq_o));
	cover property (media_start_o && media_count_o == 9'h003);
	cover property ($rose(tf_data_oe_o));
endmodule
bind atarl_core atarl_core_chk chk_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.tf_rd_n_i(tf_rd_n_i), .tf_wr_n_i(tf_wr_n_i), .tf_data_oe_o(tf_data_oe_o),
	.intrq_o(intrq_o), .media_start_o(media_start_o),
	.media_count_o(media_count_o), .media_ready_o(media_ready_o));

// *** tb/atarl_media_model.sv ***
// media stand-in: 256 data words then 52 ecc words per sector
`timescale 1ns/1ps
module atarl_media_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [8:0] count_i,
	input wire logic ready_i,
	output logic valid_o,
	output logic [15:0] data_o
);
	int n = 0;
	int tot = 0;
	logic [7:0] c = 8'h00;
	logic idle = 1'b0;
	logic [15:0] w;
	// data words carry the fetch count plus the sector index and the word index, ecc words a junk upper byte
	always_comb begin
		if (n % 308 < 256) w = {c + 8'(n / 308), 8'(n % 308)};
		else w = {8'hFF, 8'hC0 ^ 8'(n % 308 - 256)};
		valid_o = n < tot && !idle;
		data_o = valid_o ? w : ~w; // no stale word while idle
	end
	// one start streams count_i sectors once; a gap after every 7th word
	always @(posedge clk_i) begin
		if (start_i) begin
			n <= 0;
			tot <= count_i * 308;
			c <= c + 8'h01;
			idle <= 1'b0;
		end else if (valid_o && ready_i) begin
			n <= n + 1;
			idle <= n % 7 == 6;
		end else begin
			idle <= 1'b0;
		end
	end
endmodule

// *** tb/tb_ata_read_long_and_multiple.sv ***
// self-checking bench for the raw and multi-sector read engine
`timescale 1ns/1ps
module tb_ata_read_long_and_multiple;
	logic mclk_i = 0, reset_n_i = 0, tf_rd_n_i = 1, tf_wr_n_i = 1;
	logic [2:0] tf_addr_i = 3'h0;
	logic [15:0] tf_data_i = 16'h0000, tf_data_o, m_data;
	logic tf_data_oe_o, intrq_o, ecc40_sel_i = 0, m_start, m_lba;
	logic m_valid, m_ready, m_unc = 0, m_fault = 0;
	logic [7:0] block_size_i = 8'h02, r = 8'h0A, ncmd = 8'h00;
	logic [27:0] m_addr;
	logic [8:0] m_count;
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
		8'hA0, 8'h50};
	int miscompares = 0, n_tests = 0, cycles = 0;
	atarl_core dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.tf_addr_i(tf_addr_i), .tf_rd_n_i(tf_rd_n_i), .tf_wr_n_i(tf_wr_n_i),
		.tf_data_i(tf_data_i), .tf_data_o(tf_data_o),
		.tf_data_oe_o(tf_data_oe_o), .intrq_o(intrq_o),
		.ecc40_sel_i(ecc40_sel_i), .block_size_i(block_size_i),
		.media_start_o(m_start), .media_addr_o(m_addr), .media_lba_o(m_lba),
		.media_count_o(m_count), .media_valid_i(m_valid),
		.media_data_i(m_data), .media_ready_o(m_ready), .media_unc_i(m_unc),
		.media_idnf_i(m_fault), .media_amnf_i(m_fault));
	atarl_media_model media_u (.clk_i(mclk_i), .start_i(m_start),
		.count_i(m_count), .ready_i(m_ready), .valid_o(m_valid),
		.data_o(m_data));
	logic [27:0] st_addr;
	logic st_lba;
	logic [8:0] st_cnt;
	// media request as launched, taken one edge after the start pulse
	always @(posedge mclk_i) begin
		if (m_start === 1'b1) begin
			st_addr <= m_addr;
			st_lba <= m_lba;
			st_cnt <= m_count;
		end
	end
	// clock and hang guard
	initial forever #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic give_verdict;
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string m);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	// one strobed task-file access, held 8 cycles, 4 idle after
	task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d,
		output logic [15:0] q);
		r = lfsr(r);
		tf_addr_i = a;
		tf_data_i = {r, d};
		tf_wr_n_i = !w;
		tf_rd_n_i = w;
		repeat (8) @(posedge mclk_i);
		q = tf_data_o;
		#2;
		tf_wr_n_i = 1'b1;
		tf_rd_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#2;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [15:0] q;
		acc(a, 1'b1, d, q);
	endtask
	task automatic ck(input logic [2:0] a, input logic [7:0] e, input string m);
		logic [15:0] q;
		acc(a, 1'b0, 8'h00, q);
		chk({8'h00, q[7:0]}, {8'h00, e}, m);
	endtask
	task automatic wait_irq;
		int t;
		t = 0;
		while (intrq_o !== 1'b1 && t < 30000) begin
			@(posedge mclk_i);
			t++;
		end
		#2;
		chk({15'h0000, intrq_o}, 16'h0001, "interrupt");
	endtask
	// issue a command at a random address and play the host side of it
	task automatic run(input logic [7:0] op, input logic [7:0] cnt,
		input logic lba);
		logic [27:0] a;
		logic [15:0] q;
		int ns, ne, s, k;
		logic bad;
		r = lfsr(r);
		a = {r[3:0], r, ~r, 1'b0, r[6:1], 1'b1};
		ns = (cnt == 8'h00) ? 256 : cnt;
		ne = (op == 8'hC4) ? 0 : (ecc40_sel_i ? 40 : 4);
		bad = (op == 8'hC4) ? block_size_i == 8'h00 :
			op[7:1] != 7'h11 || cnt != 8'h01;
		wr(3'h2, cnt);
		wr(3'h3, a[7:0]);
		wr(3'h4, a[15:8]);
		wr(3'h5, a[23:16]);
		wr(3'h6, {1'b1, lba, 2'b10, a[27:24]});
		wr(3'h7, op);
		if (bad) begin
			wait_irq();
			ck(3'h7, 8'h51, "abort status");
			ck(3'h1, 8'h04, "abort error");
			return;
		end
		ncmd++;
		// an uncorrectable flag during the raw read must be ignored
		if (op != 8'hC4) begin
			m_unc = 1'b1;
			@(posedge mclk_i);
			#2;
			m_unc = 1'b0;
		end
		for (s = 0; s < ns; s++) begin
			if (ne != 0 || s % block_size_i == 0) begin
				wait_irq();
				ck(3'h7, 8'h58, "block status");
			end
			for (k = 0; k < 256; k++) begin
				acc(3'h0, 1'b0, 8'h00, q);
				chk(q, {ncmd + s[7:0], k[7:0]}, "data word");
			end
		end
		if (ne != 0) ck(3'h7, 8'h58, "ecc status");
		for (k = 0; k < ne; k++) begin
			acc(3'h0, 1'b0, 8'h00, q);
			chk(q, {8'h00, 8'hC0 ^ k[7:0]}, "ecc byte");
		end
		repeat (4) @(posedge mclk_i);
		#2;
		chk(st_addr[15:0], a[15:0], "media address low");
		chk({3'h0, st_lba, st_addr[27:16]}, {3'h0, lba, a[27:16]},
			"media address high");
		chk({7'h00, st_cnt}, 16'(ns), "media count");
		a = a + 28'(ns) - 28'h1;
		chk({15'h0000, intrq_o}, 16'h0000, "end interrupt");
		ck(3'h7, 8'h50, "end status");
		ck(3'h1, 8'h00, "end error");
		ck(3'h2, 8'h00, "left count");
		ck(3'h3, a[7:0], "end sector");
		ck(3'h4, a[15:8], "end cyl low");
		ck(3'h5, a[23:16], "end cyl high");
		ck(3'h6, {1'b1, lba, 2'b10, a[27:24]}, "end head");
	endtask
	// media faults while filling end the multi read with nothing handed over
	task automatic fault_run;
		wr(3'h2, 8'h02);
		wr(3'h7, 8'hC4);
		m_unc = 1'b1;
		m_fault = 1'b1;
		@(posedge mclk_i);
		#2;
		m_unc = 1'b0;
		m_fault = 1'b0;
		wait_irq();
		ck(3'h7, 8'h51, "fault status");
		ck(3'h1, 8'h51, "fault error");
		ck(3'h2, 8'h02, "fault left count");
	endtask
	// reset, register defaults, then every command kind and refusal
	initial begin
		int i;
		repeat (16) @(posedge mclk_i);
		#2;
		reset_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#2;
		for (i = 1; i < 8; i++) ck(i[2:0], rv[i], "reset value");
		run(8'h23, 8'h01, 1'b1);
		ecc40_sel_i = 1'b1;
		run(8'h22, 8'h01, 1'b0);
		run(8'h22, 8'h02, 1'b1);
		ecc40_sel_i = 1'b0;
		run(8'hC4, 8'h03, 1'b1);
		block_size_i = 8'h00;
		run(8'hC4, 8'h02, 1'b1);
		run(8'h20, 8'h01, 1'b0);
		// last, since the media stand-in is left stalled mid-stream
		block_size_i = 8'h02;
		fault_run();
		give_verdict();
	end
endmodule
